// ===== rtl/abd_pkg.sv
// package: register map, field positions, reset values and rates for the auto-baud detector
package abd_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] ABD_OFF_CONTROL = 12'h000;
    localparam logic [11:0] ABD_OFF_DIV_LOW = 12'h004;
    localparam logic [11:0] ABD_OFF_DIV_HIGH = 12'h008;
    localparam logic [11:0] ABD_OFF_RX_BUF = 12'h00c;
    localparam logic [11:0] ABD_OFF_STATUS = 12'h010;
    localparam logic [11:0] ABD_OFF_MASK = 12'h014;

    // ----------------------------------------------------------------
    // baud_control bit positions
    // ----------------------------------------------------------------
    localparam int ABD_BIT_ENABLE = 0;
    localparam int ABD_BIT_WAKE = 1;
    localparam int ABD_BIT_WIDE = 3;
    localparam int ABD_BIT_HSPEED = 4;
    localparam int ABD_BIT_OVF = 7;

    // status / mask bit positions
    localparam int ABD_IRQ_DONE = 0;
    localparam int ABD_IRQ_OVF = 1;
    localparam int ABD_IRQ_WAKE = 2;
    localparam int ABD_IRQ_N = 3;

    // ----------------------------------------------------------------
    // reset values and counts
    // ----------------------------------------------------------------
    localparam logic [15:0] ABD_DIV_RESET = 16'h0000;
    localparam logic [15:0] ABD_COUNT_START = 16'h0001;
    localparam logic [2:0] ABD_EDGES_DONE = 3'h5;
    localparam logic [ABD_IRQ_N-1:0] ABD_MASK_RESET = 3'h0;

    // calibration clock divisions: base clock divided by 512, 128 or 32
    localparam int ABD_DIV_SLOW = 512;
    localparam int ABD_DIV_MID = 128;
    localparam int ABD_DIV_FAST = 32;
    localparam int ABD_PRE_W = 9;

    typedef enum logic [1:0] {
        ABD_RATE_SLOW,
        ABD_RATE_MID,
        ABD_RATE_FAST
    } abd_rate_t;

    typedef struct packed {
        logic enable;
        logic wake;
        logic wide;
        logic hspeed;
    } abd_ctrl_t;

endpackage

// ===== rtl/abd_prescale.sv
// calibration clock divider: one-cycle enable at pclk/512, /128 or /32
`timescale 1ns/100ps
`default_nettype none
module abd_prescale
    import abd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire abd_pkg::abd_rate_t rate,
    output logic tick
);
    logic [ABD_PRE_W-1:0] cnt_q;
    logic [ABD_PRE_W-1:0] last;

    always_comb begin
        case (rate)
            ABD_RATE_SLOW: last = ABD_PRE_W'(ABD_DIV_SLOW - 1);
            ABD_RATE_MID: last = ABD_PRE_W'(ABD_DIV_MID - 1);
            ABD_RATE_FAST: last = ABD_PRE_W'(ABD_DIV_FAST - 1);
            default: last = ABD_PRE_W'(ABD_DIV_SLOW - 1);
        endcase
    end

    // restarts each measurement so the phase is tied to the first rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (!run || cnt_q >= last) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign tick = run && (cnt_q == last);

    chk_tick_gap: assert property (@(posedge pclk) disable iff (!presetn)
        tick && rate == ABD_RATE_FAST && $stable(rate) |=> !tick [*8]
    ) else $error("calibration tick came too soon");
endmodule
`default_nettype wire

// ===== rtl/abd_sync.sv
// two-stage synchroniser with rising and falling edge pulses for the receive line
`timescale 1ns/100ps
`default_nettype none
module abd_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic din,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // idle line is high, so reset to one to avoid a false edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;

    chk_rise_once: assert property (@(posedge pclk) disable iff (!presetn)
        rise |=> !rise) else $error("rise pulse lasted two cycles");
endmodule
`default_nettype wire

// ===== rtl/abd_top.sv
// auto-baud detector: apb registers, sync-character timing, overflow and receive flag
`timescale 1ns/100ps
`default_nettype none
module abd_top
    import abd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_in,
    output logic rx_idle_hold,
    output logic irq
);
    import abd_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum {
        ABD_ST_OFF,
        ABD_ST_BREAK,
        ABD_ST_START,
        ABD_ST_FIRST,
        ABD_ST_COUNT
    } abd_state_t;

    abd_state_t state_q;
    abd_ctrl_t ctrl_q;
    logic ovf_q;
    logic rx_flag_q;
    logic [15:0] div_q;
    logic [2:0] edges_q;
    logic [ABD_IRQ_N-1:0] status_q;
    logic [ABD_IRQ_N-1:0] mask_q;
    logic [31:0] prdata_q;

    logic rx_rise;
    logic rx_fall;
    logic tick;
    abd_rate_t rate;
    logic wr_en;
    logic rd_en;
    logic done_ev;
    logic ovf_ev;
    logic wake_ev;
    logic counting;
    logic wr_ctrl;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign wr_ctrl = wr_en && paddr == ABD_OFF_CONTROL;

    always_comb begin
        case (paddr)
            ABD_OFF_CONTROL, ABD_OFF_DIV_LOW, ABD_OFF_DIV_HIGH,
            ABD_OFF_RX_BUF, ABD_OFF_STATUS, ABD_OFF_MASK: pslverr = 1'b0;
            default: pslverr = psel && penable;
        endcase
    end

    abd_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din(rx_in),
        .level(),
        .rise(rx_rise),
        .fall(rx_fall)
    );

    always_comb begin
        case ({ctrl_q.wide, ctrl_q.hspeed})
            2'b00: rate = ABD_RATE_SLOW;
            2'b11: rate = ABD_RATE_FAST;
            default: rate = ABD_RATE_MID;
        endcase
    end

    assign counting = state_q == ABD_ST_COUNT;

    abd_prescale u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .run(counting),
        .rate(rate),
        .tick(tick)
    );

    // ----------------------------------------------------------------
    // calibration sequencer
    // ----------------------------------------------------------------
    assign done_ev = counting && rx_rise && edges_q == ABD_EDGES_DONE - 3'h1;
    assign ovf_ev = counting && tick && div_q == 16'hffff && !done_ev;
    assign wake_ev = ctrl_q.wake && rx_rise;
    // held from the enabling write on, so no cycle slips before the sequencer moves
    assign rx_idle_hold = ctrl_q.enable || ctrl_q.wake || state_q != ABD_ST_OFF;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ABD_ST_OFF;
        end else if (!ctrl_q.enable) begin
            state_q <= ABD_ST_OFF;
        end else begin
            case (state_q)
                ABD_ST_OFF: state_q <= ctrl_q.wake ? ABD_ST_BREAK : ABD_ST_START;
                // a wake bit cleared by software must not strand the sequencer here
                ABD_ST_BREAK: if (wake_ev || !ctrl_q.wake) state_q <= ABD_ST_START;
                ABD_ST_START: if (rx_fall) state_q <= ABD_ST_FIRST;
                ABD_ST_FIRST: if (rx_rise) state_q <= ABD_ST_COUNT;
                ABD_ST_COUNT: if (done_ev) state_q <= ABD_ST_OFF;
                default: state_q <= ABD_ST_OFF;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edges_q <= '0;
        end else if (state_q == ABD_ST_FIRST && rx_rise) begin
            edges_q <= 3'h1;
        end else if (counting && rx_rise) begin
            edges_q <= edges_q + 3'h1;
        end
    end

    // divisor pair: one 16-bit counter during calibration, else software-written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= ABD_DIV_RESET;
        end else if (state_q == ABD_ST_FIRST && rx_rise) begin
            div_q <= ABD_COUNT_START;
        end else if (counting) begin
            if (tick) begin
                div_q <= div_q + 16'h0001;
            end
        end else if (wr_en && paddr == ABD_OFF_DIV_LOW) begin
            div_q[7:0] <= pwdata[7:0];
        end else if (wr_en && paddr == ABD_OFF_DIV_HIGH) begin
            div_q[15:8] <= pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // control bits
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q.wide <= pwdata[ABD_BIT_WIDE];
                ctrl_q.hspeed <= pwdata[ABD_BIT_HSPEED];
            end
            if (done_ev) begin
                ctrl_q.enable <= 1'b0;
            end else if (wr_ctrl) begin
                ctrl_q.enable <= pwdata[ABD_BIT_ENABLE];
            end
            if (wake_ev) begin
                ctrl_q.wake <= 1'b0;
            end else if (wr_ctrl) begin
                ctrl_q.wake <= pwdata[ABD_BIT_WAKE];
            end
        end
    end

    // clear refused while enable is still set; set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_q <= 1'b0;
        end else if (ovf_ev) begin
            ovf_q <= 1'b1;
        end else if (wr_ctrl && !pwdata[ABD_BIT_OVF] && !ctrl_q.enable) begin
            ovf_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_flag_q <= 1'b0;
        end else if (done_ev) begin
            rx_flag_q <= 1'b1;
        end else if (rd_en && paddr == ABD_OFF_RX_BUF) begin
            rx_flag_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // interrupts: sticky status cleared by reading it
    // ----------------------------------------------------------------
    logic [ABD_IRQ_N-1:0] ev_vec;
    assign ev_vec = {wake_ev, ovf_ev, done_ev};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
        end else if (rd_en && paddr == ABD_OFF_STATUS) begin
            // only bits the read returned are cleared; later events survive
            status_q <= (status_q & ~prdata_q[ABD_IRQ_N-1:0]) | ev_vec;
        end else begin
            status_q <= status_q | ev_vec;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= ABD_MASK_RESET;
        end else if (wr_en && paddr == ABD_OFF_MASK) begin
            mask_q <= pwdata[ABD_IRQ_N-1:0];
        end
    end

    assign irq = |(status_q & mask_q);

    // ----------------------------------------------------------------
    // read data, registered at the setup phase
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= '0;
            case (paddr)
                ABD_OFF_CONTROL: begin
                    prdata_q[ABD_BIT_ENABLE] <= ctrl_q.enable;
                    prdata_q[ABD_BIT_WAKE] <= ctrl_q.wake;
                    prdata_q[ABD_BIT_WIDE] <= ctrl_q.wide;
                    prdata_q[ABD_BIT_HSPEED] <= ctrl_q.hspeed;
                    prdata_q[ABD_BIT_OVF] <= ovf_q;
                end
                ABD_OFF_DIV_LOW: prdata_q[7:0] <= div_q[7:0];
                ABD_OFF_DIV_HIGH: prdata_q[7:0] <= div_q[15:8];
                ABD_OFF_RX_BUF: prdata_q[8] <= rx_flag_q;
                ABD_OFF_STATUS: prdata_q[ABD_IRQ_N-1:0] <= status_q;
                ABD_OFF_MASK: prdata_q[ABD_IRQ_N-1:0] <= mask_q;
                default: prdata_q <= '0;
            endcase
        end
    end

    assign prdata = prdata_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_done_clears: assert property (@(posedge pclk) disable iff (!presetn)
        done_ev |=> !ctrl_q.enable && rx_flag_q && state_q == ABD_ST_OFF
    ) else $error("completion did not finish the sequence");
    chk_start_one: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ABD_ST_FIRST && rx_rise && ctrl_q.enable |=> div_q == 16'h0001
    ) else $error("counter did not start at one");
    chk_ovf_sets: assert property (@(posedge pclk) disable iff (!presetn)
        ovf_ev |=> ovf_q && div_q == 16'h0000
    ) else $error("overflow not flagged or no wrap");
    chk_ovf_hold: assert property (@(posedge pclk) disable iff (!presetn)
        ovf_q && ctrl_q.enable |=> ovf_q
    ) else $error("overflow cleared while enabled");
    chk_rd_clear: assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && paddr == ABD_OFF_RX_BUF && !done_ev |=> !rx_flag_q
    ) else $error("receive flag not cleared by read");
    chk_idle_hold: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q.enable |-> rx_idle_hold
    ) else $error("receiver not held idle");
    chk_wake_clear: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q.wake && rx_rise |=> !ctrl_q.wake
    ) else $error("wake enable survived rising edge");
    chk_count_step: assert property (@(posedge pclk) disable iff (!presetn)
        counting && !tick && !done_ev |=> $stable(div_q)
    ) else $error("counter moved without tick");

    // ----------------------------------------------------------------
    // sequencer, counter, clock-rate and status checks
    // ----------------------------------------------------------------
    chk_enable_go: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q.enable && state_q == ABD_ST_OFF |=> state_q != ABD_ST_OFF
    ) else $error("enable did not start calibration");
    chk_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_q.enable |=> state_q == ABD_ST_OFF
    ) else $error("sequencer ran without enable");
    chk_break_wait: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ABD_ST_BREAK && ctrl_q.enable && ctrl_q.wake && !rx_rise
            |=> state_q == ABD_ST_BREAK
    ) else $error("calibration began before break ended");
    chk_start_fall: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ABD_ST_START && ctrl_q.enable && rx_fall |=> state_q == ABD_ST_FIRST
    ) else $error("start bit not taken");
    chk_first_wait: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ABD_ST_FIRST && ctrl_q.enable && !rx_rise |=> state_q == ABD_ST_FIRST
    ) else $error("counting began before first rising edge");
    chk_no_early: assert property (@(posedge pclk) disable iff (!presetn)
        counting && ctrl_q.enable && rx_rise && !done_ev |=> state_q == ABD_ST_COUNT
    ) else $error("calibration ended before fifth rising edge");
    chk_tick_step: assert property (@(posedge pclk) disable iff (!presetn)
        counting && tick |=> div_q == $past(div_q) + 16'h0001
    ) else $error("counter did not advance on tick");
    chk_ovf_count: assert property (@(posedge pclk) disable iff (!presetn)
        counting && ctrl_q.enable && ovf_q && !done_ev |=> state_q == ABD_ST_COUNT
    ) else $error("counting stopped after overflow");
    chk_rate_pick: assert property (@(posedge pclk) disable iff (!presetn)
        rate == (ctrl_q.wide ? (ctrl_q.hspeed ? ABD_RATE_FAST : ABD_RATE_MID)
            : (ctrl_q.hspeed ? ABD_RATE_MID : ABD_RATE_SLOW))
    ) else $error("wrong calibration clock picked");
    chk_ovf_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl && !pwdata[ABD_BIT_OVF] && !ctrl_q.enable && !ovf_ev |=> !ovf_q
    ) else $error("overflow flag not cleared by write");
    chk_status_keep: assert property (@(posedge pclk) disable iff (!presetn)
        status_q[ABD_IRQ_DONE] && !rd_en |=> status_q[ABD_IRQ_DONE]
    ) else $error("done status lost before read");
    chk_status_read: assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && paddr == ABD_OFF_STATUS && prdata_q[ABD_IRQ_DONE] && !done_ev
            |=> !status_q[ABD_IRQ_DONE]
    ) else $error("done status not cleared by read");
endmodule
`default_nettype wire

// ===== test/abd_remote_tx.sv
// remote serial transmitter model that drives the receive line
`timescale 1ns/100ps
`default_nettype none
module abd_remote_tx (
    input wire logic pclk,
    output var logic tx_line
);
    // line idles high, like a pulled-up receive input
    initial tx_line = 1'b1;

    task automatic put_bit(input logic v, input int cyc);
        tx_line <= v;
        repeat (cyc) @(posedge pclk);
    endtask

    // start, eight data bits lsb first, stop; leaves the line idle high
    task automatic send_byte(input logic [7:0] b, input int cyc);
        @(posedge pclk);
        put_bit(1'b0, cyc);
        for (int i = 0; i < 8; i++) begin
            put_bit(b[i], cyc);
        end
        put_bit(1'b1, cyc);
    endtask

    // break: low for n bit times, then a few idle bit times
    task automatic send_break(input int n, input int cyc);
        @(posedge pclk);
        put_bit(1'b0, n * cyc);
        put_bit(1'b1, 4 * cyc);
    endtask
endmodule
`default_nettype wire

// ===== test/abd_top_test.sv
// self-checking bench for the auto-baud detector, driven over apb
`timescale 1ns/100ps
`default_nettype none
module abd_top_test;
    import abd_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_line;
    logic rx_idle_hold;
    logic irq;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int tests_run = 0;
    logic [11:0] offs [6] = '{ABD_OFF_CONTROL, ABD_OFF_DIV_LOW, ABD_OFF_DIV_HIGH,
                              ABD_OFF_RX_BUF, ABD_OFF_STATUS, ABD_OFF_MASK};

    always #20 pclk = ~pclk;

    abd_top dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rx_in(rx_line),
        .rx_idle_hold(rx_idle_hold),
        .irq(irq)
    );

    abd_remote_tx u_tx (
        .pclk(pclk),
        .tx_line(rx_line)
    );

    // ----------------------------------------------------------------
    // bus access and comparison
    // ----------------------------------------------------------------
    // ends at the falling edge so flags seen afterwards have settled
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // a slave that never answers is ended by the watchdog
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // one calibration; bit time puts the last edge midway between ticks
    // ----------------------------------------------------------------
    task automatic calib(input int m, input int k, input logic wake);
        int d;
        int b;
        logic [31:0] ctl;
        d = (m == 0) ? 512 : (m == 3) ? 32 : 128;
        b = (d * k + d / 2) / 8;
        ctl = 32'h1 | (32'(wake) << ABD_BIT_WAKE) | (32'(m[1]) << ABD_BIT_WIDE);
        ctl = ctl | (32'(m[0]) << ABD_BIT_HSPEED);
        apb(1'b1, ABD_OFF_MASK, (m != 0) ? 32'h5 : 32'h0);
        apb(1'b1, ABD_OFF_CONTROL, ctl);
        chk_bit("idle hold", 1'b1, rx_idle_hold);
        apb(1'b0, ABD_OFF_CONTROL, 32'h0);
        chk_val("enable set", 32'h1, rd & 32'h1);
        if (wake) begin
            u_tx.send_break(13, b);
            apb(1'b0, ABD_OFF_CONTROL, 32'h0);
            chk_val("wake cleared", 32'h1, rd & 32'h3);
            apb(1'b0, ABD_OFF_STATUS, 32'h0);
            chk_val("break event", 32'h4, rd & 32'h7);
        end
        u_tx.send_byte(8'h55, b);
        repeat (10) @(posedge pclk);
        apb(1'b0, ABD_OFF_DIV_LOW, 32'h0);
        chk_val("divisor low", (k + 1) & 32'hff, rd & 32'hff);
        apb(1'b0, ABD_OFF_DIV_HIGH, 32'h0);
        chk_val("divisor high", ((k + 1) >> 8) & 32'hff, rd & 32'hff);
        apb(1'b0, ABD_OFF_CONTROL, 32'h0);
        chk_val("control after", ctl & 32'h98, rd & 32'h9b);
        chk_bit("idle hold", 1'b0, rx_idle_hold);
        chk_bit("irq done", m != 0, irq);
        apb(1'b0, ABD_OFF_STATUS, 32'h0);
        chk_val("status", 32'h1, rd & 32'h7);
        chk_bit("irq cleared", 1'b0, irq);
        apb(1'b0, ABD_OFF_RX_BUF, 32'h0);
        chk_val("receive flag", 32'h100, rd & 32'h100);
        apb(1'b0, ABD_OFF_RX_BUF, 32'h0);
        chk_val("receive flag", 32'h0, rd & 32'h100);
        $display("test calibration mode %0d wake %b done", m, wake);
    endtask

    // ----------------------------------------------------------------
    // main sequence; overflow needs millions of cycles, so it is not run
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, offs[i], 32'h0);
            chk_val("reset value", 32'h0, rd);
        end
        apb(1'b0, 12'h020, 32'h0);
        chk_bit("unmapped error", 1'b1, err);
        chk_val("unmapped data", 32'h0, rd);
        $display("test reset done");
        calib(0, 5, 1'b0);
        calib(1, 260, 1'b0);
        calib(2, 20, 1'b0);
        calib(3, 40, 1'b0);
        calib(3, 40, 1'b1);
        apb(1'b1, ABD_OFF_CONTROL, 32'h1);
        fork
            u_tx.send_byte(8'h55, 162);
            begin
                repeat (600) @(posedge pclk);
                apb(1'b1, ABD_OFF_CONTROL, 32'h0);
                apb(1'b1, ABD_OFF_CONTROL, 32'h0);
            end
        join
        chk_bit("idle hold abort", 1'b0, rx_idle_hold);
        apb(1'b0, ABD_OFF_RX_BUF, 32'h0);
        chk_val("no receive flag", 32'h0, rd & 32'h100);
        apb(1'b1, ABD_OFF_DIV_LOW, 32'h34);
        apb(1'b1, ABD_OFF_DIV_HIGH, 32'h12);
        apb(1'b0, ABD_OFF_DIV_LOW, 32'h0);
        chk_val("divisor low", 32'h34, rd & 32'hff);
        apb(1'b0, ABD_OFF_DIV_HIGH, 32'h0);
        chk_val("divisor high", 32'h12, rd & 32'hff);
        $display("test abort done");
        final_report();
    end

    // the longest calibration alone takes about 42000 cycles
    initial begin
        repeat (90000) @(posedge pclk);
        n_mismatch++;
        final_report();
    end
endmodule
`default_nettype wire
